// ==== irq_prio_pkg.sv ====
`default_nettype none
package irq_prio_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SRC = 33;
  localparam int NUM_VEC = 28;
  localparam int FLAG_W = 32;
  localparam int HALF_W = 16;
  localparam int VEC_W = 5;
  localparam int CNT_W = 3;
  localparam int DATA_W = 32;

  // ****************************************
  // Register indices; byte address is index times four
  // ****************************************
  localparam logic [15:0] IDX_ENABLE_LOW_LO = 16'hFC00;
  localparam logic [15:0] IDX_ENABLE_LOW_HI = 16'hFC01;
  localparam logic [15:0] IDX_ENABLE_HIGH_LO = 16'hFC02;
  localparam logic [15:0] IDX_ENABLE_HIGH_HI = 16'hFC03;
  localparam logic [15:0] IDX_PENDING_LO = 16'hFC04;
  localparam logic [15:0] IDX_PENDING_HI = 16'hFC05;
  localparam logic [15:0] IDX_LAST_VECTOR = 16'hFC06;
  localparam logic [15:0] IDX_BLOCK_COUNTER = 16'hFC07;
  localparam logic [15:0] IDX_BLOCK_INC = 16'hFC08;
  localparam logic [15:0] IDX_BLOCK_DEC = 16'hFC09;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 17;
  localparam int ADDR_MSB = 31;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [HALF_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [VEC_W-1:0] VECTOR_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 3'h7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Source request line to vector: lines 2..7 share one vector
  localparam int SHARED_FIRST = 2;
  localparam int SHARED_LAST = 7;
  localparam int SHARED_VEC = 2;
  localparam int VEC_OFFSET = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic pend;
    logic write;
    logic [15:0] idx;
  } bus_access_t;

  typedef struct packed {
    logic req;
    logic [VEC_W-1:0] vector;
  } core_irq_t;

  function automatic int src_to_vec(input int src);
    if (src < SHARED_FIRST) begin
      return src;
    end else if (src <= SHARED_LAST) begin
      return SHARED_VEC;
    end else begin
      return src - VEC_OFFSET;
    end
  endfunction

endpackage
`default_nettype wire

// ==== irq_prio_pick.sv ====
`default_nettype none
module irq_prio_pick
  import irq_prio_pkg::*;
#(
  parameter int N = 32,
  parameter int IW = 5
) (
  // Per-source level and pending flag
  input wire logic [N-1:0][1:0] level,
  input wire logic [N-1:0] pend,
  // Winner
  output logic any,
  output logic [IW-1:0] idx
);

  logic [1:0] best;

  // Highest level first; on ties the later, higher vector overrides
  always_comb begin
    any = 1'b0;
    idx = '0;
    best = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && (level[i] != 2'h0) && (level[i] >= best)) begin
        any = 1'b1;
        idx = IW'(i);
        best = level[i];
      end
    end
  end

endmodule
`default_nettype wire

// ==== irq_prio_ctrl.sv ====
`default_nettype none
// What this block does
// - Enable register pair 0 holds sources 0..15, pair 1 sources 16..31.
// - High/low enable bits: 00 off, 01 level one, 10 two, 11 three.
// - Priority picks the next source, also when forwarding is re-enabled.
// - A source request sets its pending flag even when disabled.
// - Enabled pending source is issued with its vector; its flag clears.
// - Pending flags read back; disabled sources stay set for polling.
// - Writing ones clears pending flags; zero bits leave them alone.
// - Last issued vector is readable at index 0xFC06.
// - Nonzero 3-bit block counter stops all forwarding to the core.
// - Every issued request increments the block counter unless a direct counter write lands in the same cycle.
// - Any write to index 0xFC08 increments the counter, which stops at 7.
// - Issue plus increment write in one cycle adds two.
// - Any write to index 0xFC09 decrements the counter unless that would take it below zero.
// - Reading index 0xFC07 returns the counter.
// - 33 request lines map onto 28 vectors; some share a vector.
module irq_prio_ctrl
  import irq_prio_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Peripheral request lines, same clock
  input wire logic [NUM_SRC-1:0] SRC_REQ,
  // Toward the core
  output logic CORE_INT_REQ,
  output logic [VEC_W-1:0] CORE_INT_VECTOR
);

  // ****************************************
  // State
  // ****************************************
  logic [FLAG_W-1:0] en_low_q;
  logic [FLAG_W-1:0] en_high_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  core_irq_t core_q;
  core_irq_t core_d;
  bus_access_t acc_q;
  logic ready_q;
  logic [DATA_W-1:0] rdata_q;

  // ****************************************
  // Bus address phase
  // ****************************************
  logic addr_ok;
  logic take;
  logic [15:0] haddr_idx;

  assign haddr_idx = HADDR[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign addr_ok = (HADDR[ADDR_MSB:ADDR_IDX_MSB+1] == '0);
  assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  // Only whole words are used, so HSIZE is not decoded
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_q <= '0;
    end else if (take) begin
      acc_q.pend <= addr_ok;
      acc_q.write <= HWRITE;
      acc_q.idx <= haddr_idx;
    end else if (HREADY) begin
      acc_q.pend <= 1'b0;
    end
  end

  // ****************************************
  // Write strobes for the data phase
  // ****************************************
  logic wr;
  logic wr_enl0;
  logic wr_enl1;
  logic wr_enh0;
  logic wr_enh1;
  logic wr_flg0;
  logic wr_flg1;
  logic wr_cnt;
  logic wr_inc;
  logic wr_dec;

  assign wr = acc_q.pend && acc_q.write;

  always_comb begin
    wr_enl0 = 1'b0;
    wr_enl1 = 1'b0;
    wr_enh0 = 1'b0;
    wr_enh1 = 1'b0;
    wr_flg0 = 1'b0;
    wr_flg1 = 1'b0;
    wr_cnt = 1'b0;
    wr_inc = 1'b0;
    wr_dec = 1'b0;
    if (!wr) begin
      wr_enl0 = 1'b0;
    end else if (acc_q.idx == IDX_ENABLE_LOW_LO) begin
      wr_enl0 = 1'b1;
    end else if (acc_q.idx == IDX_ENABLE_LOW_HI) begin
      wr_enl1 = 1'b1;
    end else if (acc_q.idx == IDX_ENABLE_HIGH_LO) begin
      wr_enh0 = 1'b1;
    end else if (acc_q.idx == IDX_ENABLE_HIGH_HI) begin
      wr_enh1 = 1'b1;
    end else if (acc_q.idx == IDX_PENDING_LO) begin
      wr_flg0 = 1'b1;
    end else if (acc_q.idx == IDX_PENDING_HI) begin
      wr_flg1 = 1'b1;
    end else if (acc_q.idx == IDX_BLOCK_COUNTER) begin
      wr_cnt = 1'b1;
    end else if (acc_q.idx == IDX_BLOCK_INC) begin
      wr_inc = 1'b1;
    end else if (acc_q.idx == IDX_BLOCK_DEC) begin
      wr_dec = 1'b1;
    end
  end

  // ****************************************
  // Enable registers
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en_low_q <= {ENABLE_RESET, ENABLE_RESET};
    end else if (wr_enl0) begin
      en_low_q[HALF_W-1:0] <= HWDATA[HALF_W-1:0];
    end else if (wr_enl1) begin
      en_low_q[FLAG_W-1:HALF_W] <= HWDATA[HALF_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en_high_q <= {ENABLE_RESET, ENABLE_RESET};
    end else if (wr_enh0) begin
      en_high_q[HALF_W-1:0] <= HWDATA[HALF_W-1:0];
    end else if (wr_enh1) begin
      en_high_q[FLAG_W-1:HALF_W] <= HWDATA[HALF_W-1:0];
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  logic [FLAG_W-1:0][1:0] level;
  logic pick_any;
  logic [VEC_W-1:0] pick_idx;
  logic issue;

  always_comb begin
    for (int i = 0; i < FLAG_W; i++) begin
      level[i] = {en_high_q[i], en_low_q[i]};
    end
  end

  // Disabled sources carry level zero and are never picked
  irq_prio_pick #(
    .N(FLAG_W),
    .IW(VEC_W)
  ) u_pick (
    .level(level),
    .pend(flags_q),
    .any(pick_any),
    .idx(pick_idx)
  );

  // Flags that waited while blocked compete again once the counter is zero
  assign issue = pick_any && (cnt_q == CNT_RESET);

  // ****************************************
  // Pending flags
  // ****************************************
  logic [FLAG_W-1:0] set_mask;
  logic [FLAG_W-1:0] clr_mask;

  always_comb begin
    set_mask = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (SRC_REQ[s]) begin
        set_mask[src_to_vec(s)] = 1'b1;
      end
    end
  end

  always_comb begin
    clr_mask = '0;
    if (wr_flg0) begin
      clr_mask[HALF_W-1:0] = HWDATA[HALF_W-1:0];
    end
    if (wr_flg1) begin
      clr_mask[FLAG_W-1:HALF_W] = HWDATA[HALF_W-1:0];
    end
    if (issue) begin
      clr_mask[pick_idx] = 1'b1;
    end
  end

  // A request in the clearing cycle wins, so no event is lost
  always_comb begin
    flags_d = (flags_q & ~clr_mask) | set_mask;
    flags_d[FLAG_W-1:NUM_VEC] = '0;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // Block counter
  // ****************************************
  logic [CNT_W:0] cnt_up;

  always_comb begin
    cnt_up = {1'b0, cnt_q} + {{CNT_W{1'b0}}, issue} + {{CNT_W{1'b0}}, wr_inc};
    if (wr_dec && (cnt_up != '0)) begin
      cnt_up = cnt_up - {{CNT_W{1'b0}}, 1'b1};
    end
    if (cnt_up > {1'b0, CNT_MAX}) begin
      cnt_d = CNT_MAX;
    end else begin
      cnt_d = cnt_up[CNT_W-1:0];
    end
    // Direct writes are allowed but meant to be avoided by software
    if (wr_cnt) begin
      cnt_d = HWDATA[CNT_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Core request and last vector
  // ****************************************
  always_comb begin
    core_d.req = issue;
    core_d.vector = core_q.vector;
    if (issue) begin
      core_d.vector = pick_idx;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      core_q <= '{req: 1'b0, vector: VECTOR_RESET};
    end else begin
      core_q <= core_d;
    end
  end

  assign CORE_INT_REQ = core_q.req;
  assign CORE_INT_VECTOR = core_q.vector;

  // ****************************************
  // Read data with one wait state
  // ****************************************
  // The wait state lets a read see a write made just before it
  // Ready drops at the address edge, so the first data cycle is always the wait
  logic rd_wait;
  logic resp_q;
  logic [DATA_W-1:0] rmux;

  assign rd_wait = !ready_q;

  // Reads outside the index window come back as zero
  always_comb begin
    rmux = RDATA_ZERO;
    if (!acc_q.pend) begin
      rmux = RDATA_ZERO;
    end else if (acc_q.idx == IDX_ENABLE_LOW_LO) begin
      rmux[HALF_W-1:0] = en_low_q[HALF_W-1:0];
    end else if (acc_q.idx == IDX_ENABLE_LOW_HI) begin
      rmux[HALF_W-1:0] = en_low_q[FLAG_W-1:HALF_W];
    end else if (acc_q.idx == IDX_ENABLE_HIGH_LO) begin
      rmux[HALF_W-1:0] = en_high_q[HALF_W-1:0];
    end else if (acc_q.idx == IDX_ENABLE_HIGH_HI) begin
      rmux[HALF_W-1:0] = en_high_q[FLAG_W-1:HALF_W];
    end else if (acc_q.idx == IDX_PENDING_LO) begin
      rmux[HALF_W-1:0] = flags_q[HALF_W-1:0];
    end else if (acc_q.idx == IDX_PENDING_HI) begin
      rmux[HALF_W-1:0] = flags_q[FLAG_W-1:HALF_W];
    end else if (acc_q.idx == IDX_LAST_VECTOR) begin
      rmux[VEC_W-1:0] = core_q.vector;
    end else if (acc_q.idx == IDX_BLOCK_COUNTER) begin
      rmux[CNT_W-1:0] = cnt_q;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ready_q <= 1'b1;
    end else if (take && !HWRITE) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= RDATA_ZERO;
    end else if (rd_wait) begin
      rdata_q <= rmux;
    end
  end

  // Every transfer is answered OKAY, still from a flop like the other outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      resp_q <= HRESP_OKAY;
    end else begin
      resp_q <= HRESP_OKAY;
    end
  end

  assign HREADYOUT = ready_q;
  assign HRDATA = rdata_q;
  assign HRESP = resp_q;

endmodule
`default_nettype wire

// ==== irq_prio_ctrl_props.sv ====
`default_nettype none
module irq_prio_ctrl_props
  import irq_prio_pkg::*;
(
  // Bus
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  // Core
  input wire logic CORE_INT_REQ,
  input wire logic [VEC_W-1:0] CORE_INT_VECTOR
);
  // ***
  // Bus phases
  // ***
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic tk;
  logic wt;
  logic [15:0] ix;
  assign tk = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  assign wt = tk && HWRITE;
  assign ix = HADDR[17:2];
  sequence rd_at(logic [15:0] i);
    tk && !HWRITE && ix == i;
  endsequence
  sequence rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  a_read_wait: assert property (tk && !HWRITE |=> rd_wait)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (wt |=> HREADYOUT)
    else $error("write stalled");
  a_unmapped_zero: assert property (tk && !HWRITE && ix > IDX_BLOCK_DEC |-> ##2 HRDATA == '0)
    else $error("unmapped read not zero");
  a_count_width: assert property (rd_at(IDX_BLOCK_COUNTER) |-> ##2 HRDATA[31:3] == '0)
    else $error("counter read too wide");
  a_vector_read: assert property (
    rd_at(IDX_LAST_VECTOR) ##2 !CORE_INT_REQ |-> HRDATA == {27'h0, CORE_INT_VECTOR})
    else $error("vector readback differs");
  a_vector_hold: assert property ($changed(CORE_INT_VECTOR) |-> CORE_INT_REQ)
    else $error("vector changed without issue");
  a_vector_range: assert property (CORE_INT_REQ |-> CORE_INT_VECTOR < NUM_VEC)
    else $error("vector out of range");
  // A write two edges back may have lowered the counter again
  a_issue_blocks: assert property (CORE_INT_REQ && !$past(wt, 2) |=> !CORE_INT_REQ)
    else $error("issue not blocked");
endmodule
bind irq_prio_ctrl irq_prio_ctrl_props irq_prio_ctrl_props_inst (
  .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .CORE_INT_REQ(CORE_INT_REQ), .CORE_INT_VECTOR(CORE_INT_VECTOR));
`default_nettype wire

// ==== irq_core_model.sv ====
`default_nettype none
module irq_core_model (
  // Clock and request
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [4:0] vec,
  // Taken interrupt
  output logic taken,
  output logic [4:0] taken_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  // Core latches the vector that comes with each request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 1'b0;
      taken_vec <= 5'h00;
    end else begin
      taken <= req;
      if (req) begin
        taken_vec <= vec;
      end
    end
  end
endmodule
`default_nettype wire

// ==== irq_prio_ctrl_tb_top.sv ====
`default_nettype none
module irq_prio_ctrl_tb_top;
  import irq_prio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b1;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [NUM_SRC-1:0] SRC_REQ = '0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, CORE_INT_REQ, taken;
  logic [VEC_W-1:0] CORE_INT_VECTOR, taken_vec;
  logic rd_ph = 1'b0;
  logic [31:0] lfsr = 32'h0001_7836;
  logic [15:0] ix;
  int s, v;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] exp_rd[$];
  logic [VEC_W-1:0] exp_vec[$];

  irq_prio_ctrl irq_prio_ctrl_inst (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SRC_REQ(SRC_REQ), .CORE_INT_REQ(CORE_INT_REQ), .CORE_INT_VECTOR(CORE_INT_VECTOR));
  irq_core_model irq_core_model_inst (.clk(CLK), .rst_n(RESET_N), .req(CORE_INT_REQ),
    .vec(CORE_INT_VECTOR), .taken(taken), .taken_vec(taken_vec));

  // ***
  // Helpers
  // ***
  initial begin
    forever #10 CLK = ~CLK;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t result mismatch", $time);
    end
  endtask
  // Flop-driven ready is steady at the falling edge, so no race with the rising one
  task automatic wait_rdy;
    @(negedge CLK);
    while (HREADYOUT !== 1'b1) @(negedge CLK);
    @(posedge CLK);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= 1'b1;
    HADDR <= {14'h0, i, 2'h0};
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    exp_rd.push_back(e);
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= 1'b0;
    HADDR <= {14'h0, i, 2'h0};
    wait_rdy();
    HTRANS <= 2'h0;
    rd_ph <= 1'b1;
    wait_rdy();
    rd_ph <= 1'b0;
  endtask
  always @(negedge CLK) begin
    if (rd_ph && HREADYOUT === 1'b1) begin
      check(exp_rd.size() > 0 && HRDATA === exp_rd.pop_front());
      check(HRESP === HRESP_OKAY);
    end
    if (taken === 1'b1) begin
      check(exp_vec.size() > 0 && taken_vec === exp_vec.pop_front());
    end
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  // ***
  // Scenarios
  // ***
  initial begin
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 8; i++) rd(IDX_ENABLE_LOW_LO + 16'(i), 32'h0);
    wr(IDX_BLOCK_INC, 32'h0000_1234);
    // Lines 8..12 reach vectors 3..7, set to levels one, two, two, three, off
    wr(IDX_ENABLE_LOW_LO, 32'h0000_0048);
    wr(IDX_ENABLE_HIGH_LO, 32'h0000_0070);
    SRC_REQ <= 33'h0_0000_1F00;
    @(posedge CLK);
    SRC_REQ <= '0;
    rd(IDX_PENDING_LO, 32'h0000_00F8);
    rd(IDX_BLOCK_COUNTER, 32'h1);
    exp_vec = {5'h06, 5'h05, 5'h04, 5'h03};
    repeat (5) wr(IDX_BLOCK_DEC, 32'h0);
    rd(IDX_PENDING_LO, 32'h0000_0080);
    rd(IDX_LAST_VECTOR, 32'h3);
    rd(IDX_BLOCK_COUNTER, 32'h0);
    wr(IDX_PENDING_LO, 32'h0000_FF7F);
    rd(IDX_PENDING_LO, 32'h0000_0080);
    wr(IDX_PENDING_LO, 32'h0000_0080);
    rd(IDX_PENDING_LO, 32'h0);
    wr(16'hFC10, 32'hFFFF_FFFF);
    rd(16'hFC10, 32'h0);
    repeat (9) wr(IDX_BLOCK_INC, 32'hFFFF_FFFF);
    rd(IDX_BLOCK_COUNTER, 32'h7);
    repeat (9) wr(IDX_BLOCK_DEC, 32'h0);
    rd(IDX_BLOCK_COUNTER, 32'h0);
    repeat (6) begin
      lfsr = next_rand(lfsr);
      s = int'(lfsr % 32'h21);
      v = s < 2 ? s : (s < 8 ? 2 : s - 5);
      // Enables and flags are indexed by vector, not by request line
      ix = v < 16 ? IDX_ENABLE_LOW_LO : IDX_ENABLE_LOW_HI;
      wr(ix, 32'h1 << (v < 16 ? v : v - 16));
      exp_vec.push_back(5'(v));
      SRC_REQ <= 33'h1 << s;
      @(posedge CLK);
      SRC_REQ <= '0;
      repeat (3) @(posedge CLK);
      wr(IDX_BLOCK_DEC, 32'h0);
      wr(ix, 32'h0);
    end
    repeat (10) @(posedge CLK);
    check(exp_vec.size() == 0);
    complete_run();
  end
endmodule
`default_nettype wire
